// ==== src/dlpm_merge.v ====
`include "dlpm_defs.vh"

// =========================================================
// one receiver link: sampling, line buffer, timing measure
module dlpm_link #(
  parameter PIX_W      = `DLPM_PIX_W,
  parameter CNT_W      = `DLPM_CNT_W,
  parameter DEPTH      = `DLPM_FIFO_DEPTH,
  parameter AW         = 7,
  parameter LOSS_CYCLES = `DLPM_LOSS_CYCLES
) (
  // system
  input  wire             clock,
  input  wire             reset,
  // receiver pins
  input  wire             out_clk_in,
  input  wire [PIX_W-1:0] data_in,
  input  wire             de_in,
  input  wire             ctl3_in,
  input  wire             sync_flag_in,
  // buffer read side
  input  wire             pop,
  output wire             head_valid,
  output wire [PIX_W-1:0] head_data,
  output wire             head_start,
  output reg              overflow_reg,
  // measurements
  output reg  [CNT_W-1:0] line_len_reg,
  output reg  [CNT_W-1:0] active_len_reg,
  output wire             stable,
  output reg              enc_reg,
  output reg              sync_flag_reg
);
  localparam [CNT_W-1:0] CNT_ONE = 1;
  localparam [31:0] LOSS = LOSS_CYCLES;
  localparam [3:0]  STABLE_N = `DLPM_STABLE_LINES;

  // =========================================================
  // two-stage sampling of every pin
  reg [PIX_W+3:0] s1_reg;
  reg [PIX_W+3:0] s2_reg;
  reg             clk_d_reg;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      s1_reg    <= {(PIX_W+4){1'b0}};
      s2_reg    <= {(PIX_W+4){1'b0}};
      clk_d_reg <= 1'b0;
    end else begin
      s1_reg    <= {out_clk_in, ctl3_in, sync_flag_in, de_in, data_in};
      s2_reg    <= s1_reg;
      clk_d_reg <= s2_reg[PIX_W+3];
    end
  end
  wire             pix_edge = s2_reg[PIX_W+3] & ~clk_d_reg;
  wire             de_s     = s2_reg[PIX_W];
  wire [PIX_W-1:0] data_s   = s2_reg[PIX_W-1:0];

  // =========================================================
  // pixel-edge domain events, seen in system clock
  reg              de_d_reg;
  reg              armed_reg;
  reg              first_reg;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      de_d_reg      <= 1'b0;
      armed_reg     <= 1'b0;
      first_reg     <= 1'b0;
      enc_reg       <= 1'b0;
      sync_flag_reg <= 1'b0;
    end else begin
      sync_flag_reg <= s2_reg[PIX_W+1];
      if (pix_edge) begin
        de_d_reg <= de_s;
        enc_reg  <= s2_reg[PIX_W+2];
        if (de_s & ~de_d_reg) begin
          armed_reg <= 1'b1;
          first_reg <= 1'b1;
        end else if (de_s) begin
          first_reg <= 1'b0;
        end
      end
    end
  end
  wire de_rise  = pix_edge & de_s & ~de_d_reg;
  wire line_pix = pix_edge & de_s & (armed_reg | de_rise);
  wire start_px = de_rise;

  // =========================================================
  // line buffer, flip-flop storage
  reg [PIX_W:0] mem_reg [0:DEPTH-1];
  reg [AW:0]    wr_reg;
  reg [AW:0]    rd_reg;
  wire [AW:0]   fill = wr_reg - rd_reg;
  wire          full = (fill == DEPTH);
  assign head_valid = (wr_reg != rd_reg);
  assign head_data  = mem_reg[rd_reg[AW-1:0]][PIX_W-1:0];
  assign head_start = mem_reg[rd_reg[AW-1:0]][PIX_W];
  wire do_wr = line_pix & ~full;
  wire do_rd = pop & head_valid;
  integer i;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_reg       <= {(AW+1){1'b0}};
      rd_reg       <= {(AW+1){1'b0}};
      overflow_reg <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_reg[i] <= {(PIX_W+1){1'b0}};
      end
    end else begin
      overflow_reg <= line_pix & full;
      if (do_wr) begin
        mem_reg[wr_reg[AW-1:0]] <= {start_px, data_s};
        wr_reg <= wr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end

  // =========================================================
  // line timing: length and active width per line
  reg [CNT_W-1:0] pix_cnt_reg;
  reg [CNT_W-1:0] act_cnt_reg;
  reg [3:0]       stab_reg;
  reg [31:0]      loss_reg;
  wire in_limits = (pix_cnt_reg >= `DLPM_MIN_LINE) && (pix_cnt_reg <= `DLPM_MAX_LINE)
                   && (act_cnt_reg != {CNT_W{1'b0}}) && (act_cnt_reg <= `DLPM_MAX_ACTIVE);
  wire same_line = (pix_cnt_reg == line_len_reg) && (act_cnt_reg == active_len_reg);
  assign stable = (stab_reg == STABLE_N);
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pix_cnt_reg    <= {CNT_W{1'b0}};
      act_cnt_reg    <= {CNT_W{1'b0}};
      line_len_reg   <= {CNT_W{1'b0}};
      active_len_reg <= {CNT_W{1'b0}};
      stab_reg       <= 4'h0;
      loss_reg       <= 32'h0;
    end else begin
      if (de_rise) begin
        line_len_reg   <= pix_cnt_reg;
        active_len_reg <= act_cnt_reg;
        pix_cnt_reg    <= CNT_ONE;
        act_cnt_reg    <= CNT_ONE;
        loss_reg       <= 32'h0;
        // stability counts matching in-limit lines
        if (in_limits && same_line) begin
          if (!stable) begin
            stab_reg <= stab_reg + 4'h1;
          end
        end else begin
          stab_reg <= 4'h0;
        end
      end else begin
        if (pix_edge && pix_cnt_reg != {CNT_W{1'b1}}) begin
          pix_cnt_reg <= pix_cnt_reg + CNT_ONE;
        end
        if (pix_edge && de_s && act_cnt_reg != {CNT_W{1'b1}}) begin
          act_cnt_reg <= act_cnt_reg + CNT_ONE;
        end
        // lines that stop arriving drop the link
        if (loss_reg >= LOSS - 32'h1) begin
          stab_reg <= 4'h0;
        end else begin
          loss_reg <= loss_reg + 32'h1;
        end
      end
    end
  end
endmodule

// =========================================================
// top: two links merged into one dual-link pixel stream
module dlpm_merge #(
  parameter PIX_W       = `DLPM_PIX_W,
  parameter CNT_W       = `DLPM_CNT_W,
  parameter DEPTH       = `DLPM_FIFO_DEPTH,
  parameter AW          = 7,
  parameter LOSS_CYCLES = `DLPM_LOSS_CYCLES,
  parameter [6:0] PRIMARY_DDC = `DLPM_DDC_PRIMARY
) (
  // system
  input  wire             clock,
  input  wire             reset,
  // primary receiver
  input  wire             pri_out_clk,
  input  wire [PIX_W-1:0] pri_data,
  input  wire             pri_de,
  input  wire             pri_ctl3,
  input  wire             pri_sync_detect_flag,
  // secondary receiver
  input  wire             sec_out_clk,
  input  wire [PIX_W-1:0] sec_data,
  input  wire             sec_de,
  input  wire             sec_ctl3,
  input  wire             sec_sync_detect_flag,
  // merged stream
  output reg              pix_valid_reg,
  output reg              pix_start_reg,
  output reg  [PIX_W-1:0] pix_even_reg,
  output reg  [PIX_W-1:0] pix_odd_reg,
  // status
  output reg              dual_mode_reg,
  output reg              format_ok_reg,
  output reg              spurious_sync_reg,
  output reg              overflow_reg,
  output reg              pri_encrypted_reg,
  output reg              sec_encrypted_reg,
  // receiver strap values
  output wire [6:0]       pri_ddc_addr,
  output wire [6:0]       sec_ddc_addr
);
  localparam [7:0] SEC_DDC = `DLPM_DDC_SECONDARY;

  // each receiver has its own key memory and identical map
  assign pri_ddc_addr = PRIMARY_DDC;
  assign sec_ddc_addr = SEC_DDC[6:0];

  wire             a_valid, b_valid, a_start, b_start, a_ovf, b_ovf;
  wire             a_stable, b_stable, a_enc, b_enc, a_flag, b_flag;
  wire [PIX_W-1:0] a_data, b_data;
  wire [CNT_W-1:0] a_line, a_act, b_line, b_act;
  reg              pop_a, pop_b;
  reg              aligned_reg;

  dlpm_link #(.PIX_W(PIX_W), .CNT_W(CNT_W), .DEPTH(DEPTH), .AW(AW),
              .LOSS_CYCLES(LOSS_CYCLES)) u_pri (
    .clock(clock), .reset(reset),
    .out_clk_in(pri_out_clk), .data_in(pri_data), .de_in(pri_de),
    .ctl3_in(pri_ctl3), .sync_flag_in(pri_sync_detect_flag),
    .pop(pop_a), .head_valid(a_valid), .head_data(a_data), .head_start(a_start),
    .overflow_reg(a_ovf), .line_len_reg(a_line), .active_len_reg(a_act),
    .stable(a_stable), .enc_reg(a_enc), .sync_flag_reg(a_flag)
  );
  dlpm_link #(.PIX_W(PIX_W), .CNT_W(CNT_W), .DEPTH(DEPTH), .AW(AW),
              .LOSS_CYCLES(LOSS_CYCLES)) u_sec (
    .clock(clock), .reset(reset),
    .out_clk_in(sec_out_clk), .data_in(sec_data), .de_in(sec_de),
    .ctl3_in(sec_ctl3), .sync_flag_in(sec_sync_detect_flag),
    .pop(pop_b), .head_valid(b_valid), .head_data(b_data), .head_start(b_start),
    .overflow_reg(b_ovf), .line_len_reg(b_line), .active_len_reg(b_act),
    .stable(b_stable), .enc_reg(b_enc), .sync_flag_reg(b_flag)
  );

  // =========================================================
  // format decision from timing, secondary flag only reported
  wire dual_next = a_stable & b_stable & (a_line == b_line) & (a_act == b_act);
  wire ok_next   = a_stable;

  // =========================================================
  // pairing: heads must both start a line or both continue one
  wire both     = a_valid & b_valid;
  wire matched  = both & (a_start == b_start);
  reg  emit;
  always @* begin
    pop_a = 1'b0;
    pop_b = 1'b0;
    emit  = 1'b0;
    if (dual_mode_reg) begin
      if (matched & (aligned_reg | a_start)) begin
        pop_a = 1'b1;
        pop_b = 1'b1;
        emit  = 1'b1;
      end else if (both & a_start) begin
        pop_b = 1'b1; // stale tail of secondary line
      end else if (both & b_start) begin
        pop_a = 1'b1;
      end else if (~aligned_reg & a_valid & ~a_start) begin
        pop_a = 1'b1; // line already under way when dual mode began
      end else if (~aligned_reg & b_valid & ~b_start) begin
        pop_b = 1'b1;
      end
    end else begin
      // single link: secondary buffer is drained so noise never backs up
      pop_a = a_valid;
      pop_b = b_valid;
      emit  = a_valid;
    end
  end

  // =========================================================
  // registered outputs
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pix_valid_reg     <= 1'b0;
      pix_start_reg     <= 1'b0;
      pix_even_reg      <= {PIX_W{1'b0}};
      pix_odd_reg       <= {PIX_W{1'b0}};
      dual_mode_reg     <= 1'b0;
      format_ok_reg     <= 1'b0;
      spurious_sync_reg <= 1'b0;
      overflow_reg      <= 1'b0;
      pri_encrypted_reg <= 1'b0;
      sec_encrypted_reg <= 1'b0;
      aligned_reg       <= 1'b0;
    end else begin
      // pairing locks only on a pair of line starts
      aligned_reg       <= dual_mode_reg & (aligned_reg | (emit & a_start));
      dual_mode_reg     <= dual_next;
      format_ok_reg     <= ok_next;
      spurious_sync_reg <= b_flag & ~dual_next;
      overflow_reg      <= a_ovf | b_ovf;
      pri_encrypted_reg <= a_enc;
      sec_encrypted_reg <= b_enc & dual_next;
      pix_valid_reg     <= emit & format_ok_reg;
      pix_start_reg     <= emit & format_ok_reg & a_start;
      if (emit) begin
        pix_even_reg <= a_data;
        pix_odd_reg  <= dual_mode_reg ? b_data : {PIX_W{1'b0}};
      end
    end
  end
endmodule

// ==== src/dlpm_defs.vh ====
// What this block does
// - pixels from both receiver clock domains are re-timed into one system clock domain
// - the buffers present matching primary and secondary pixels together as one pair
// - buffer depth is a parameter trading delay tolerance against area
// - in dual-link mode both receivers decode and raise their sync-detect flags
// - an idle secondary receiver keeps clocking out and decoding noise
// - a sync-detect flag can be raised by noise, so it never proves activity
// - link activity is decided here, not from the receivers' sync-detect flags
// - sync timing and stability from both links classify dual or single; the primary link alone decides support
// - single-receiver timing is checked against supportable limits before acceptance
// - the secondary receiver's display data channel address is set to 0x76
// - the secondary receiver keeps the same HDCP register map as the primary
// - each receiver reads identical keys from its own separate key memory
// - each receiver encrypts the contents of its own key memory its own way
// - encryption status arrives on control bit three of each link, the secondary's reported only in dual mode
// - no fixed delay or clock phase is assumed between the two receivers
`ifndef DLPM_DEFS_VH
`define DLPM_DEFS_VH

// =========================================================
// widths and buffer
`define DLPM_PIX_W        24
`define DLPM_CNT_W        16
`define DLPM_FIFO_DEPTH   128

// =========================================================
// format limits, in pixels, and stable line count
`define DLPM_MIN_LINE     16'h0040
`define DLPM_MAX_LINE     16'h1000
`define DLPM_MAX_ACTIVE   16'h0c00
`define DLPM_STABLE_LINES 4

// =========================================================
// timing
`define DLPM_CLK_PERIOD_NS 4
`define DLPM_LOSS_TIME_NS  100000
`define DLPM_LOSS_CYCLES   (`DLPM_LOSS_TIME_NS / `DLPM_CLK_PERIOD_NS)

// =========================================================
// display data channel addresses
`define DLPM_DDC_PRIMARY   7'h3a
`define DLPM_DDC_SECONDARY 8'h76

`endif

// ==== tb/dlpm_merge_chk.sv ====
module dlpm_merge_chk #(
  parameter       PIX_W       = 24,
  parameter [6:0] PRIMARY_DDC = 7'h3a
) (
  // system
  input wire             clock,
  input wire             reset,
  // watched ports
  input wire             pri_ctl3,
  input wire             pix_valid_reg,
  input wire             pix_start_reg,
  input wire [PIX_W-1:0] pix_odd_reg,
  input wire             dual_mode_reg,
  input wire             format_ok_reg,
  input wire             pri_encrypted_reg,
  input wire             sec_encrypted_reg,
  input wire [6:0]       pri_ddc_addr,
  input wire [6:0]       sec_ddc_addr
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // =========================================================
  // sequences
  sequence s_quiet;
    !pix_valid_reg [*3];
  endsequence
  sequence s_emit;
    pix_valid_reg ##1 !pix_valid_reg;
  endsequence

  // =========================================================
  // properties
  a_quiet_start: assert property ($fell(reset) |-> s_quiet)
    else $error("pair emitted right after reset");
  a_valid_pulse: assert property (pix_valid_reg |-> s_emit)
    else $error("merged valid held two cycles");
  a_valid_fmt: assert property (pix_valid_reg |-> $past(format_ok_reg))
    else $error("pair emitted without accepted format");
  a_dual_fmt: assert property (dual_mode_reg |-> format_ok_reg)
    else $error("dual mode without accepted format");
  a_odd_single: assert property (pix_valid_reg && !$past(dual_mode_reg) |-> pix_odd_reg == '0)
    else $error("odd pixel not zero in single mode");
  a_start_valid: assert property (pix_start_reg |-> pix_valid_reg)
    else $error("line start without pair");
  a_sec_enc: assert property (sec_encrypted_reg |-> dual_mode_reg || $past(dual_mode_reg))
    else $error("secondary encryption outside dual mode");
  a_pri_enc: assert property ($rose(pri_ctl3) |-> ##[1:60] pri_encrypted_reg)
    else $error("primary encryption status not followed");
  a_ddc_addr: assert property (sec_ddc_addr == 7'h76 && pri_ddc_addr == PRIMARY_DDC)
    else $error("display channel address wrong");
endmodule

// ==== tb/dlpm_rx_model.sv ====
module dlpm_rx_model #(
  parameter int         SKEW = 0,
  parameter int         ACT  = 8,
  parameter realtime    PH   = 0.0,
  parameter logic [7:0] TAG  = 8'h00
) (
  output logic        out_clk,
  output logic [23:0] data,
  output logic        de,
  output logic        ctl3,
  output logic        sync_flag,
  input  wire logic   active,
  input  wire logic   enc,
  input  wire logic [15:0] line_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pos  = '0;
  logic [7:0]  line = '0;

  initial begin
    {out_clk, de, ctl3, sync_flag} = 4'h0;
    data = '0;
    #(PH);
    forever #80 out_clk = ~out_clk; // runs on while the link is idle
  end

  // outputs change on the falling edge so the merge samples them settled on the rise
  always @(negedge out_clk) begin
    if (pos + 16'h1 >= line_len) begin
      pos = '0;
      line = line + 8'h1;
    end else begin
      pos = pos + 16'h1;
    end
    if (active) begin
      de = (pos >= SKEW) && (pos < SKEW + ACT); // own pipeline delay
      data = de ? {TAG, line, 8'(pos - SKEW)} : ~data;
    end else begin
      de = pos[0]; // crosstalk decoded as enable edges
      data = ~data;
    end
    ctl3 = enc & active;
    sync_flag = 1'b1; // noise raises it as well
  end
endmodule

// ==== tb/test_dlpm_merge.sv ====
`include "dlpm_defs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module test_dlpm_merge;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, reset = 1'b1, sec_act = 1'b1;
  // both receivers HDCP capable; transmitter signals each link on its own
  logic        pri_enc = 1'b1, sec_enc = 1'b1, ovf_seen = 1'b0;
  logic [15:0] pri_len = 16'h0040;
  logic        pri_out_clk, pri_de, pri_ctl3, pri_sync_detect_flag;
  logic        sec_out_clk, sec_de, sec_ctl3, sec_sync_detect_flag;
  logic [23:0] pri_data, sec_data, pix_even_reg, pix_odd_reg;
  logic        pix_valid_reg, pix_start_reg, dual_mode_reg, format_ok_reg;
  logic        spurious_sync_reg, overflow_reg, pri_encrypted_reg, sec_encrypted_reg;
  logic [6:0]  pri_ddc_addr, sec_ddc_addr;
  int          miscompares = 0, checks = 0, n, k;

  dlpm_rx_model #(.SKEW(2), .PH(1.3), .TAG(8'h11)) dlpm_rx_model_pri_i (
    .out_clk(pri_out_clk), .data(pri_data), .de(pri_de), .ctl3(pri_ctl3),
    .sync_flag(pri_sync_detect_flag), .active(1'b1), .enc(pri_enc), .line_len(pri_len));
  dlpm_rx_model #(.SKEW(7), .PH(37.0), .TAG(8'h22)) dlpm_rx_model_sec_i (
    .out_clk(sec_out_clk), .data(sec_data), .de(sec_de), .ctl3(sec_ctl3),
    .sync_flag(sec_sync_detect_flag), .active(sec_act), .enc(sec_enc), .line_len(pri_len));
  // loss limit just above one line time keeps the run short
  dlpm_merge #(.LOSS_CYCLES(4000)) dlpm_merge_i (
    .clock(clock), .reset(reset), .pri_out_clk(pri_out_clk), .pri_data(pri_data),
    .pri_de(pri_de), .pri_ctl3(pri_ctl3), .pri_sync_detect_flag(pri_sync_detect_flag),
    .sec_out_clk(sec_out_clk), .sec_data(sec_data), .sec_de(sec_de), .sec_ctl3(sec_ctl3),
    .sec_sync_detect_flag(sec_sync_detect_flag), .pix_valid_reg(pix_valid_reg),
    .pix_start_reg(pix_start_reg), .pix_even_reg(pix_even_reg), .pix_odd_reg(pix_odd_reg),
    .dual_mode_reg(dual_mode_reg), .format_ok_reg(format_ok_reg),
    .spurious_sync_reg(spurious_sync_reg), .overflow_reg(overflow_reg),
    .pri_encrypted_reg(pri_encrypted_reg), .sec_encrypted_reg(sec_encrypted_reg),
    .pri_ddc_addr(pri_ddc_addr), .sec_ddc_addr(sec_ddc_addr));

  // lost pixels are remembered until the end of the run
  always @(negedge clock) begin
    if (overflow_reg === 1'b1) ovf_seen <= 1'b1;
  end

  // =========================================================
  // helpers
  task automatic wait_pair(input logic need_start, input int lim);
    for (n = 0; n < lim && !(pix_valid_reg === 1'b1 && (pix_start_reg === 1'b1 || !need_start)); n++)
      @(negedge clock);
  endtask

  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // =========================================================
  // scenarios
  task automatic t_reset;
    `CHK("valid", 1'b0, pix_valid_reg)
    `CHK("dual", 1'b0, dual_mode_reg)
    `CHK("sec_ddc", 7'h76, sec_ddc_addr)
    `CHK("pri_ddc", `DLPM_DDC_PRIMARY, pri_ddc_addr)
    $display("t_reset done");
  endtask

  task automatic t_dual;
    for (n = 0; n < 30000 && dual_mode_reg !== 1'b1; n++) @(negedge clock);
    @(negedge clock);
    `CHK("dual", 1'b1, dual_mode_reg)
    `CHK("format_ok", 1'b1, format_ok_reg)
    `CHK("spurious", 1'b0, spurious_sync_reg)
    `CHK("pri_enc", 1'b1, pri_encrypted_reg)
    `CHK("sec_enc", 1'b1, sec_encrypted_reg)
    // a line already under way when dual mode starts must not leave as pairs
    k = 0;
    for (n = 0; n < 4000 && !(pix_valid_reg === 1'b1 && pix_start_reg === 1'b1); n++) begin
      if (pix_valid_reg === 1'b1) k++;
      @(negedge clock);
    end
    `CHK("early_pairs", 0, k)
    for (k = 0; k < 8; k++) begin
      if (k > 0) begin
        @(negedge clock);
        wait_pair(1'b0, 200);
      end
      `CHK("even", {8'h11, pix_even_reg[15:8], 8'(k)}, pix_even_reg)
      `CHK("odd", {8'h22, pix_even_reg[15:0]}, pix_odd_reg)
      `CHK("start", k == 0, pix_start_reg)
    end
    $display("t_dual done");
  endtask

  task automatic t_enc;
    {pri_enc, sec_enc} = 2'b00;
    repeat (100) @(negedge clock);
    `CHK("pri_enc", 1'b0, pri_encrypted_reg)
    `CHK("sec_enc", 1'b0, sec_encrypted_reg)
    {pri_enc, sec_enc} = 2'b10;
    repeat (100) @(negedge clock);
    `CHK("pri_enc", 1'b1, pri_encrypted_reg)
    `CHK("sec_enc", 1'b0, sec_encrypted_reg)
    {pri_enc, sec_enc} = 2'b01;
    repeat (100) @(negedge clock);
    `CHK("pri_enc", 1'b0, pri_encrypted_reg)
    `CHK("sec_enc", 1'b1, sec_encrypted_reg)
    {pri_enc, sec_enc} = 2'b11;
    repeat (100) @(negedge clock);
    `CHK("dual", 1'b1, dual_mode_reg)
    $display("t_enc done");
  endtask

  task automatic t_single;
    sec_act = 1'b0; // second link switched off
    for (n = 0; n < 5000 && dual_mode_reg !== 1'b0; n++) @(negedge clock);
    repeat (3000) @(negedge clock);
    `CHK("dual", 1'b0, dual_mode_reg)
    `CHK("spurious", 1'b1, spurious_sync_reg)
    `CHK("format_ok", 1'b1, format_ok_reg)
    `CHK("sec_enc", 1'b0, sec_encrypted_reg)
    wait_pair(1'b1, 4000);
    `CHK("odd", 24'h0, pix_odd_reg)
    `CHK("even_tag", 8'h11, pix_even_reg[23:16])
    `CHK("overflow", 1'b0, ovf_seen)
    $display("t_single done");
  endtask

  task automatic t_badfmt;
    pri_len = 16'h003f; // one pixel short of the shortest line
    for (n = 0; n < 15000 && format_ok_reg !== 1'b0; n++) @(negedge clock);
    `CHK("format_ok", 1'b0, format_ok_reg)
    k = 0;
    repeat (3000) begin
      @(negedge clock);
      if (pix_valid_reg !== 1'b0) k++;
    end
    `CHK("pairs", 0, k)
    $display("t_badfmt done");
  endtask

  initial begin
    forever #2 clock = ~clock;
  end

  initial begin
    #300us;
    miscompares++;
    $display("watchdog expired");
    finish_test;
  end

  initial begin
    repeat (8) @(negedge clock);
    reset = 1'b0;
    t_reset;
    t_dual;
    t_enc;
    t_single;
    t_badfmt;
    finish_test;
  end
endmodule

bind dlpm_merge dlpm_merge_chk #(.PIX_W(PIX_W), .PRIMARY_DDC(PRIMARY_DDC)) dlpm_merge_chk_i (
  .clock(clock), .reset(reset), .pri_ctl3(pri_ctl3), .pix_valid_reg(pix_valid_reg),
  .pix_start_reg(pix_start_reg), .pix_odd_reg(pix_odd_reg), .dual_mode_reg(dual_mode_reg),
  .format_ok_reg(format_ok_reg), .pri_encrypted_reg(pri_encrypted_reg),
  .sec_encrypted_reg(sec_encrypted_reg), .pri_ddc_addr(pri_ddc_addr),
  .sec_ddc_addr(sec_ddc_addr));
